// *** fdcst_defines.vh ***
`ifndef FDCST_DEFINES_VH
`define FDCST_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define FDCST_CLK_PERIOD_NS 100
`define FDCST_MS_NS 1000000
`define FDCST_SRT_BASE 5'h10
`define FDCST_MNT_ZERO_MS 8'h80
// load, tick and done each cost a clock; presetting the divider gives them back
`define FDCST_TICK_PRESET 32'h3

// ----------------------------------------
// opcodes and command lengths
// ----------------------------------------
`define FDCST_OP_SEEK 8'h0F
`define FDCST_OP_SENSE_DRV 8'h04
`define FDCST_OP_SENSE_INT 8'h08
`define FDCST_OP_SCAN_LE 5'h19
`define FDCST_OP_TRACK 7'h21
`define FDCST_TRACK_B1 5'h06
`define FDCST_LEN_SEEK 4'h3
`define FDCST_LEN_SEEK_ETR 4'h4
`define FDCST_LEN_SENSE_DRV 4'h2
`define FDCST_LEN_SENSE_INT 4'h1
`define FDCST_LEN_SCAN 4'h9
`define FDCST_LEN_TRACK 4'h3
`define FDCST_LEN_RES_SCAN 3'h7

// ----------------------------------------
// status encodings
// ----------------------------------------
`define FDCST_ST0_READY 3'h6
`define FDCST_ST0_SEEK_OK 3'h1
`define FDCST_ST0_INVALID 8'h80
`define FDCST_ST3_ONES 8'h28
`define FDCST_MSR_RQM 7
`define FDCST_MSR_DIO 6
`define FDCST_MSR_CB 4

`endif

// *** fdcst_delay_timer.v ***
`timescale 1ns/1ps
// counts down whole milliseconds; done pulses on the tick that ends the delay
module fdcst_delay_timer #(
    parameter W = 8
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_load,
    input wire [W-1:0] i_value,
    input wire i_tick,
    output reg o_done
);
    reg [W-1:0] count;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= {W{1'b0}};
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_load) begin
                count <= i_value;
            end else if (i_tick && count != {W{1'b0}}) begin
                count <= count - {{(W-1){1'b0}}, 1'b1};
                o_done <= (count == {{(W-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule

// *** fdcst_scan_cmp.v ***
`timescale 1ns/1ps
// per-sector scan comparison, most significant byte first
module fdcst_scan_cmp (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_sector_start,
    input wire i_valid,
    input wire [7:0] i_disk,
    input wire [7:0] i_host,
    output reg o_equal,
    output reg o_above
);
    reg decided;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_equal <= 1'b1;
            o_above <= 1'b0;
            decided <= 1'b0;
        end else if (i_sector_start) begin
            o_equal <= 1'b1;
            o_above <= 1'b0;
            decided <= 1'b0;
        end else if (i_valid && !decided && i_disk != i_host) begin
            // first differing byte settles the whole sector
            decided <= 1'b1;
            o_equal <= 1'b0;
            o_above <= (i_disk > i_host);
        end
    end
endmodule

// *** fdcst_top.v ***
`timescale 1ns/1ps
`include "fdcst_defines.vh"
module fdcst_top #(
    parameter MS_CYCLES = `FDCST_MS_NS / `FDCST_CLK_PERIOD_NS
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_cmd_wr,
    input wire [7:0] i_cmd_data,
    input wire i_res_rd,
    input wire i_etr,
    input wire [3:0] i_step_rate,
    input wire [6:0] i_motor_on,
    input wire [3:0] i_drive_ready,
    input wire i_write_protect,
    input wire i_track0,
    input wire i_two_side,
    input wire i_result_entry,
    input wire i_nondma_xfer,
    input wire i_scan_sector_start,
    input wire i_scan_valid,
    input wire [7:0] i_scan_disk,
    input wire [7:0] i_scan_host,
    input wire i_scan_done,
    output reg [7:0] o_main_status,
    output reg [7:0] o_res_data,
    output reg o_irq,
    output reg o_step,
    output reg o_dir,
    output reg o_scan_active
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam P_CMD = 2'h0;
    localparam P_DO = 2'h1;
    localparam P_EXEC = 2'h2;
    localparam P_RES = 2'h3;
    localparam K_IDLE = 2'h0;
    localparam K_MOTOR = 2'h1;
    localparam K_STEP = 2'h2;

    reg [1:0] p_state;
    reg [1:0] k_state;
    reg [3:0] cmd_cnt;
    reg [3:0] cmd_len;
    reg [7:0] cmd_buf [0:8];
    reg [7:0] res_buf [0:6];
    reg [2:0] res_idx;
    reg [2:0] res_len;
    reg [7:0] ptr_lo [0:3];
    reg [7:0] ptr_hi [0:3];
    reg [3:0] drv_busy;
    reg [3:0] pend_seek;
    reg [3:0] pend_ready;
    reg [3:0] ready_prev;
    reg poll_armed;
    reg poll_en;
    reg auto_int;
    reg sns_active;
    reg [1:0] sns_drv;
    reg [1:0] sk_drv;
    reg [11:0] sk_target;
    reg [31:0] ms_cnt;
    reg ms_tick;
    reg tmr_load;
    reg [7:0] tmr_value;
    wire tmr_done;
    wire scan_equal;
    wire scan_above;
    integer i;
    integer j;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    wire [11:0] cur_trk = {ptr_hi[sk_drv][3:0], ptr_lo[sk_drv]};
    wire [7:0] op = cmd_buf[0];
    wire [1:0] c_drv = cmd_buf[1][1:0];
    wire c_head = cmd_buf[1][2];
    wire [7:0] step_ms = {3'h0, `FDCST_SRT_BASE - {1'b0, i_step_rate}};
    wire [7:0] motor_ms = (i_motor_on == 7'h00) ? `FDCST_MNT_ZERO_MS : {1'b0, i_motor_on};
    wire seek_end = (k_state != K_IDLE) && tmr_done && (cur_trk == sk_target);
    wire sns_clr = (p_state == P_RES) && i_res_rd && (res_idx == 3'h0) && sns_active;
    wire [3:0] ready_chg = poll_en ? (i_drive_ready ^ ready_prev) : 4'h0;
    wire [3:0] pend_any = pend_seek | pend_ready;
    reg [1:0] pick;
    reg [3:0] new_len;

    always @* begin
        pick = 2'h0;
        for (j = 3; j >= 0; j = j - 1) begin
            if (pend_any[j]) begin
                pick = j[1:0];
            end
        end
    end

    always @* begin
        if (i_cmd_data == `FDCST_OP_SEEK) begin
            new_len = i_etr ? `FDCST_LEN_SEEK_ETR : `FDCST_LEN_SEEK;
        end else if (i_cmd_data == `FDCST_OP_SENSE_DRV) begin
            new_len = `FDCST_LEN_SENSE_DRV;
        end else if (i_cmd_data == `FDCST_OP_SENSE_INT) begin
            new_len = `FDCST_LEN_SENSE_INT;
        end else if (i_cmd_data[4:0] == `FDCST_OP_SCAN_LE) begin
            new_len = `FDCST_LEN_SCAN;
        end else if ({i_cmd_data[7], i_cmd_data[5:0]} == `FDCST_OP_TRACK) begin
            new_len = `FDCST_LEN_TRACK;
        end else begin
            new_len = 4'h1;
        end
    end

    // ----------------------------------------
    // sub blocks
    // ----------------------------------------
    fdcst_delay_timer #(
        .W(8)
    ) u_timer (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .i_tick(ms_tick),
        .o_done(tmr_done)
    );

    fdcst_scan_cmp u_scan (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_sector_start(i_scan_sector_start),
        .i_valid(i_scan_valid & o_scan_active),
        .i_disk(i_scan_disk),
        .i_host(i_scan_host),
        .o_equal(scan_equal),
        .o_above(scan_above)
    );

    // ----------------------------------------
    // main sequencer
    // ----------------------------------------
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            p_state <= P_CMD;
            k_state <= K_IDLE;
            cmd_cnt <= 4'h0;
            cmd_len <= 4'h1;
            res_idx <= 3'h0;
            res_len <= 3'h1;
            for (i = 0; i < 9; i = i + 1) begin
                cmd_buf[i] <= 8'h00;
            end
            for (i = 0; i < 7; i = i + 1) begin
                res_buf[i] <= 8'h00;
            end
            for (i = 0; i < 4; i = i + 1) begin
                ptr_lo[i] <= 8'h00;
                ptr_hi[i] <= 8'h00;
            end
            drv_busy <= 4'h0;
            pend_seek <= 4'h0;
            pend_ready <= 4'h0;
            ready_prev <= 4'h0;
            poll_armed <= 1'b0;
            poll_en <= 1'b0;
            auto_int <= 1'b0;
            sns_active <= 1'b0;
            sns_drv <= 2'h0;
            sk_drv <= 2'h0;
            sk_target <= 12'h000;
            ms_cnt <= 32'h0;
            ms_tick <= 1'b0;
            tmr_load <= 1'b0;
            tmr_value <= 8'h01;
            o_main_status <= 8'h00;
            o_res_data <= 8'h00;
            o_irq <= 1'b0;
            o_step <= 1'b0;
            o_dir <= 1'b0;
            o_scan_active <= 1'b0;
        end else begin
            tmr_load <= 1'b0;
            o_step <= 1'b0;

            // millisecond enable, preset on each load so a delay ends exactly n ms after its request;
            // limitation: MS_CYCLES must exceed the preset
            if (tmr_load) begin
                ms_cnt <= `FDCST_TICK_PRESET;
            end else if (ms_cnt == MS_CYCLES - 1) begin
                ms_cnt <= 32'h0;
            end else begin
                ms_cnt <= ms_cnt + 32'h1;
            end
            ms_tick <= !tmr_load && (ms_cnt == MS_CYCLES - 1);

            // ready polling begins once the lines are sampled after reset
            if (!poll_armed) begin
                poll_armed <= 1'b1;
                poll_en <= 1'b1;
                ready_prev <= i_drive_ready;
            end else begin
                ready_prev <= i_drive_ready;
            end

            // cleared by first result read, ready only if no seek is pending for that drive; a new event wins
            pend_ready <= (pend_ready & ~((sns_clr && !pend_seek[sns_drv]) ? (4'h1 << sns_drv) : 4'h0))
                | ready_chg;
            pend_seek <= (pend_seek & ~(sns_clr ? (4'h1 << sns_drv) : 4'h0))
                | (seek_end ? (4'h1 << sk_drv) : 4'h0);

            // transfer interrupts clear on fifo access
            auto_int <= (auto_int & ~(i_cmd_wr | i_res_rd)) | i_result_entry | i_nondma_xfer
                | (p_state == P_EXEC && i_scan_done);

            o_irq <= auto_int | (|pend_seek) | (|pend_ready);
            o_main_status <= {(p_state == P_CMD || p_state == P_RES), (p_state == P_RES), 1'b0,
                (p_state != P_CMD || cmd_cnt != 4'h0), drv_busy};

            // ----------------------------------------
            // seek engine
            // ----------------------------------------
            case (k_state)
                K_IDLE: begin
                end
                K_MOTOR, K_STEP: begin
                    if (tmr_done) begin
                        if (cur_trk == sk_target) begin
                            // interrupt one period after last step
                            drv_busy[sk_drv] <= 1'b0;
                            k_state <= K_IDLE;
                        end else begin
                            o_step <= 1'b1;
                            if (sk_target > cur_trk) begin
                                ptr_lo[sk_drv] <= cur_trk[7:0] + 8'h01;
                                ptr_hi[sk_drv][3:0] <= (cur_trk[7:0] == 8'hFF) ? cur_trk[11:8] + 4'h1
                                    : cur_trk[11:8];
                            end else begin
                                ptr_lo[sk_drv] <= cur_trk[7:0] - 8'h01;
                                ptr_hi[sk_drv][3:0] <= (cur_trk[7:0] == 8'h00) ? cur_trk[11:8] - 4'h1
                                    : cur_trk[11:8];
                            end
                            tmr_load <= 1'b1;
                            tmr_value <= step_ms;
                            k_state <= K_STEP;
                        end
                    end
                end
                default: begin
                    k_state <= K_IDLE;
                end
            endcase

            // ----------------------------------------
            // command, execution and result phases
            // ----------------------------------------
            case (p_state)
                P_CMD: begin
                    if (i_cmd_wr) begin
                        cmd_buf[cmd_cnt] <= i_cmd_data;
                        if (cmd_cnt == 4'h0) begin
                            poll_en <= 1'b0;
                            cmd_len <= new_len;
                            if (new_len == 4'h1) begin
                                p_state <= P_DO;
                            end else begin
                                cmd_cnt <= 4'h1;
                            end
                        end else if (cmd_cnt + 4'h1 == cmd_len) begin
                            cmd_cnt <= 4'h0;
                            p_state <= P_DO;
                        end else begin
                            cmd_cnt <= cmd_cnt + 4'h1;
                        end
                    end
                end
                P_DO: begin
                    p_state <= P_RES;
                    res_idx <= 3'h0;
                    res_len <= 3'h1;
                    sns_active <= 1'b0;
                    res_buf[0] <= `FDCST_ST0_INVALID;
                    o_res_data <= `FDCST_ST0_INVALID;
                    if (op == `FDCST_OP_SEEK) begin
                        p_state <= P_CMD;
                        sk_drv <= c_drv;
                        sk_target <= i_etr ? {cmd_buf[3][7:4], cmd_buf[2]} : {4'h0, cmd_buf[2]};
                        o_dir <= (i_etr ? {cmd_buf[3][7:4], cmd_buf[2]} : {4'h0, cmd_buf[2]})
                            > {ptr_hi[c_drv][3:0], ptr_lo[c_drv]};
                        drv_busy[c_drv] <= 1'b1;
                        tmr_load <= 1'b1;
                        tmr_value <= motor_ms;
                        k_state <= K_MOTOR;
                    end else if (op == `FDCST_OP_SENSE_DRV) begin
                        res_buf[0] <= `FDCST_ST3_ONES | {1'b0, i_write_protect, 1'b0, i_track0,
                            1'b0, c_head, c_drv};
                        o_res_data <= `FDCST_ST3_ONES | {1'b0, i_write_protect, 1'b0, i_track0,
                            1'b0, c_head, c_drv};
                    end else if (op == `FDCST_OP_SENSE_INT) begin
                        if (pend_any != 4'h0) begin
                            sns_active <= 1'b1;
                            sns_drv <= pick;
                            res_len <= i_etr ? 3'h3 : 3'h2;
                            res_buf[0] <= {(pend_seek[pick] ? `FDCST_ST0_SEEK_OK : `FDCST_ST0_READY),
                                3'h0, pick};
                            o_res_data <= {(pend_seek[pick] ? `FDCST_ST0_SEEK_OK : `FDCST_ST0_READY),
                                3'h0, pick};
                            res_buf[1] <= ptr_lo[pick];
                            res_buf[2] <= {ptr_hi[pick][3:0], 4'h0};
                        end
                    end else if (op[4:0] == `FDCST_OP_SCAN_LE) begin
                        p_state <= P_EXEC;
                        o_scan_active <= 1'b1;
                    end else if ({op[7], op[5:0]} == `FDCST_OP_TRACK
                        && cmd_buf[1][7:3] == `FDCST_TRACK_B1) begin
                        if (op[6]) begin
                            if (cmd_buf[1][2]) begin
                                ptr_hi[c_drv] <= cmd_buf[2];
                            end else begin
                                ptr_lo[c_drv] <= cmd_buf[2];
                            end
                            res_buf[0] <= cmd_buf[2];
                            o_res_data <= cmd_buf[2];
                        end else begin
                            res_buf[0] <= cmd_buf[1][2] ? ptr_hi[c_drv] : ptr_lo[c_drv];
                            o_res_data <= cmd_buf[1][2] ? ptr_hi[c_drv] : ptr_lo[c_drv];
                        end
                    end
                end
                P_EXEC: begin
                    if (i_scan_done) begin
                        // status two bits 3 and 2
                        o_scan_active <= 1'b0;
                        p_state <= P_RES;
                        res_idx <= 3'h0;
                        res_len <= `FDCST_LEN_RES_SCAN;
                        res_buf[0] <= {5'h00, c_head, c_drv};
                        o_res_data <= {5'h00, c_head, c_drv};
                        res_buf[1] <= 8'h00;
                        res_buf[2] <= {4'h0, scan_equal, scan_above, 2'h0};
                        res_buf[3] <= cmd_buf[2];
                        res_buf[4] <= cmd_buf[3];
                        res_buf[5] <= cmd_buf[4];
                        res_buf[6] <= cmd_buf[5];
                    end
                end
                P_RES: begin
                    if (i_res_rd) begin
                        if (res_idx + 3'h1 == res_len) begin
                            p_state <= P_CMD;
                            sns_active <= 1'b0;
                        end else begin
                            res_idx <= res_idx + 3'h1;
                            o_res_data <= res_buf[res_idx + 3'h1];
                        end
                    end
                end
                default: begin
                    p_state <= P_CMD;
                end
            endcase
        end
    end

    // two-sided input reserved for the drive status byte layout
    wire unused_two_side = i_two_side;
endmodule

// *** fdcst_monitor.sv ***
`timescale 1ns/1ps
module fdcst_monitor #(
    parameter MS_CYCLES = 4
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_res_rd,
    input wire [3:0] i_step_rate,
    input wire [7:0] o_main_status,
    input wire [7:0] o_res_data,
    input wire o_irq,
    input wire o_step,
    input wire o_dir,
    input wire o_scan_active
);
    // --------------------------
    // step spacing bookkeeping
    // --------------------------
    int gap;
    logic stepped;
    // first step of a seek has no previous step to measure from
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap <= 0;
            stepped <= 1'b0;
        end else begin
            gap <= o_step ? 1 : gap + 1;
            stepped <= o_step | (stepped & (|o_main_status[3:0]));
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_seek_go; $rose(|o_main_status[3:0]); endsequence
    sequence s_quiet; !o_step [*3]; endsequence
    property p_motor_wait; s_seek_go |-> s_quiet; endproperty
    a_motor_wait: assert property (p_motor_wait) else $error("step before motor time");
    property p_step_pulse; o_step |=> !o_step; endproperty
    a_step_pulse: assert property (p_step_pulse) else $error("step wider than a cycle");
    property p_step_space; o_step && stepped |-> gap == (16 - i_step_rate) * MS_CYCLES; endproperty
    a_step_space: assert property (p_step_space) else $error("step spacing wrong");
    property p_step_busy; o_step |-> |o_main_status[3:0]; endproperty
    a_step_busy: assert property (p_step_busy) else $error("step without busy drive");
    property p_step_idle; o_step |-> !o_main_status[4]; endproperty
    a_step_idle: assert property (p_step_idle) else $error("step outside idle");
    property p_dir_hold; o_step |-> $stable(o_dir); endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved at step");
    property p_seek_irq; $fell(|o_main_status[3:0]) |-> ##[0:2] o_irq; endproperty
    a_seek_irq: assert property (p_seek_irq) else $error("no irq at seek end");
    property p_res_stand; o_main_status[7:6] == 2'b11 && !i_res_rd |=> $stable(o_res_data); endproperty
    a_res_stand: assert property (p_res_stand) else $error("result byte moved");
    property p_scan_busy; o_scan_active |-> o_main_status[4]; endproperty
    a_scan_busy: assert property (p_scan_busy) else $error("scan without busy");
endmodule

bind fdcst_top fdcst_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_res_rd(i_res_rd), .i_step_rate(i_step_rate), .o_main_status(o_main_status), .o_res_data(o_res_data),
    .o_irq(o_irq), .o_step(o_step), .o_dir(o_dir), .o_scan_active(o_scan_active));

// *** fdcst_host_model.sv ***
`timescale 1ns/1ps
module fdcst_host_model (
    input wire i_clock,
    input wire [7:0] i_main_status,
    input wire [7:0] i_res_data,
    output logic o_cmd_wr,
    output logic [7:0] o_cmd_data,
    output logic o_res_rd
);
    // --------------------------
    // host side of the data port
    // --------------------------
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd_data = 8'hA5;
        o_res_rd = 1'b0;
    end
    task automatic put(input logic [7:0] b, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(negedge i_clock);
            ok = (i_main_status[7:6] === 2'b10);
        end
        if (ok) begin
            o_cmd_wr <= 1'b1;
            o_cmd_data <= b;
            @(negedge i_clock);
            o_cmd_wr <= 1'b0;
            // idle data bus shows garbage, not the last byte
            o_cmd_data <= ~b;
        end
    endtask
    task automatic get(output logic [7:0] b, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(negedge i_clock);
            ok = (i_main_status[7:6] === 2'b11);
        end
        b = i_res_data;
        if (ok) begin
            o_res_rd <= 1'b1;
            @(negedge i_clock);
            o_res_rd <= 1'b0;
        end
    endtask
endmodule

// *** fdc_seek_sense_track_commands_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module fdc_seek_sense_track_commands_tb_top;
    localparam int MS = 4;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic extended_track_range, wp, trk0, rent, ndma, sstart, svalid, sdone;
    logic [3:0] srt, ready;
    logic [6:0] mon;
    logic [7:0] sdisk, shost;
    logic [15:0] seed = 16'h0010;
    wire cmd_wr, res_rd, irq, step, dir, sact;
    wire [7:0] cmd_data, main_status_reg, res;
    int fail_count = 0;
    int cmp_count = 0;
    int ptr[4];
    int sd[3] = '{1, 2, 2};
    int st[3] = '{12'h0A8, 12'h102, 12'h005};
    bit sx[3] = '{1'b0, 1'b1, 1'b0};
    logic [3:0] sr[3] = '{4'hF, 4'hE, 4'hD};
    logic [6:0] sm[3] = '{7'h01, 7'h00, 7'h02};
    logic [7:0] st2x[3] = '{8'h08, 8'h00, 8'h04};
    always #50 i_clock = ~i_clock;
    fdcst_top #(.MS_CYCLES(MS)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cmd_wr(cmd_wr),
        .i_cmd_data(cmd_data), .i_res_rd(res_rd), .i_etr(extended_track_range), .i_step_rate(srt), .i_motor_on(mon),
        .i_drive_ready(ready), .i_write_protect(wp), .i_track0(trk0), .i_two_side(1'b0),
        .i_result_entry(rent), .i_nondma_xfer(ndma), .i_scan_sector_start(sstart), .i_scan_valid(svalid),
        .i_scan_disk(sdisk), .i_scan_host(shost), .i_scan_done(sdone), .o_main_status(main_status_reg),
        .o_res_data(res), .o_irq(irq), .o_step(step), .o_dir(dir), .o_scan_active(sact));
    fdcst_host_model host (.i_clock(i_clock), .i_main_status(main_status_reg), .i_res_data(res), .o_cmd_wr(cmd_wr),
        .o_cmd_data(cmd_data), .o_res_rd(res_rd));
    // --------------------------
    // bench helpers
    // --------------------------
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic give_up();
        fail_count++;
        $display("ERROR t=%0t wait ran out", $time);
        print_verdict();
    endtask
    task automatic cmd(input logic [7:0] q[$]);
        bit ok;
        foreach (q[i]) begin
            host.put(q[i], ok);
            if (!ok) give_up();
        end
    endtask
    task automatic expect_res(input logic [7:0] m, input logic [7:0] e);
        bit ok;
        logic [7:0] b;
        host.get(b, ok);
        if (!ok) give_up();
        `CHK(b & m, e)
    endtask
    task automatic seek(input int d, input int tgt, input bit x, input logic [3:0] r, input logic [6:0] m);
        int t, n, first, last, mm, iv;
        mm = (m == 7'h00 ? 128 : m) * MS;
        iv = (16 - r) * MS;
        extended_track_range = x;
        srt = r;
        mon = m;
        if (x) cmd('{8'h0F, 8'(d), tgt[7:0], {tgt[11:8], 4'h0}});
        else cmd('{8'h0F, 8'(d), tgt[7:0]});
        repeat (3) @(negedge i_clock);
        `CHK(main_status_reg[3:0], 4'(1 << d))
        first = -1;
        last = 0;
        n = 0;
        for (t = 0; t < 8000 && irq !== 1'b1; t++) begin
            if (step === 1'b1) begin
                if (first < 0) first = t;
                last = t;
                n++;
                `CHK(dir, 1'(tgt > ptr[d]))
            end
            @(negedge i_clock);
        end
        if (t == 8000) give_up();
        `CHK(n, tgt > ptr[d] ? tgt - ptr[d] : ptr[d] - tgt)
        `CHK(first >= mm - 3 && first <= mm + 2, 1'b1)
        `CHK(t - last >= iv && t - last <= iv + 3, 1'b1)
        cmd('{8'h08});
        expect_res(8'hE3, 8'(8'h20 | d));
        expect_res(8'hFF, tgt[7:0]);
        if (x) expect_res(8'hFF, {tgt[11:8], 4'h0});
        ptr[d] = tgt;
        repeat (2) @(negedge i_clock);
        `CHK(irq, 1'b0)
    endtask
    // --------------------------
    // main sequence
    // --------------------------
    initial begin
        {extended_track_range, wp, trk0, rent, ndma, sstart, svalid, sdone} = 8'h00;
        srt = 4'hF;
        mon = 7'h01;
        ready = 4'hF;
        sdisk = 8'h00;
        shost = 8'h00;
        repeat (6) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clock);
        ready[0] = 1'b0;
        repeat (3) @(negedge i_clock);
        `CHK(irq, 1'b1)
        cmd('{8'h08});
        expect_res(8'hE3, 8'hC0);
        expect_res(8'hFF, 8'h00);
        cmd('{8'h08});
        expect_res(8'hFF, 8'h80);
        repeat (2) @(negedge i_clock);
        `CHK(main_status_reg, 8'h80)
        for (int d = 0; d < 4; d++) begin
            ptr[d] = rnd();
            cmd('{8'h61, 8'(8'h30 | d), ptr[d][7:0]});
            expect_res(8'hFF, ptr[d][7:0]);
        end
        for (int k = 0; k < 8; k++) begin
            cmd('{8'h21, 8'(8'h30 | k), rnd()});
            expect_res(8'hFF, k[2] ? 8'h00 : ptr[k[1:0]][7:0]);
        end
        cmd('{8'h61, 8'h37, 8'hC3});
        expect_res(8'hFF, 8'hC3);
        cmd('{8'h21, 8'h37, 8'h00});
        expect_res(8'hFF, 8'hC3);
        cmd('{8'h21, 8'h77, 8'h00});
        expect_res(8'hFF, 8'h80);
        `CHK(irq, 1'b0)
        for (int k = 0; k < 2; k++) begin
            {wp, trk0} = 2'(rnd());
            rent = (k == 0);
            ndma = (k == 1);
            @(negedge i_clock);
            rent = 1'b0;
            ndma = 1'b0;
            repeat (2) @(negedge i_clock);
            `CHK(irq, 1'b1)
            cmd('{8'h04, 8'(8'h04 | k * 3)});
            `CHK(irq, 1'b0)
            expect_res(8'hFF, {1'b0, wp, 1'b1, trk0, 1'b1, 1'b1, 2'(k * 3)});
            `CHK(irq, 1'b0)
        end
        for (int k = 0; k < 3; k++) begin
            cmd('{8'(8'h19 | k << 5), 8'h05, 8'h12, 8'h01, 8'h03, 8'h02, 8'h09, 8'h1B, 8'h01});
            repeat (3) @(negedge i_clock);
            `CHK(sact, 1'b1)
            sstart = 1'b1;
            @(negedge i_clock);
            sstart = 1'b0;
            svalid = 1'b1;
            for (int j = 0; j < 4; j++) begin
                sdisk = rnd() & 8'h7E | 8'h01;
                shost = (j == 2) ? sdisk + 8'(k == 1) - 8'(k == 2) : sdisk;
                @(negedge i_clock);
            end
            svalid = 1'b0;
            sdone = 1'b1;
            @(negedge i_clock);
            sdone = 1'b0;
            repeat (3) @(negedge i_clock);
            `CHK(irq, 1'b1)
            expect_res(8'hFF, 8'h05);
            expect_res(8'hFF, 8'h00);
            `CHK(irq, 1'b0)
            expect_res(8'h0C, st2x[k]);
            expect_res(8'hFF, 8'h12);
            expect_res(8'hFF, 8'h01);
            expect_res(8'hFF, 8'h03);
            expect_res(8'hFF, 8'h02);
        end
        for (int s = 0; s < 3; s++) seek(sd[s], st[s], sx[s], sr[s], sm[s]);
        print_verdict();
    end
endmodule
